/* File: core/fault_supervisor_defines.svh */
/*
  constants for the regulator fault supervisor: register offsets, field
  positions, reset values and timing counts.
  assumes the clock runs at the period given here.
*/
`ifndef FAULT_SUPERVISOR_DEFINES_SVH
`define FAULT_SUPERVISOR_DEFINES_SVH

// clock period in ns
`define CLK_PERIOD_NS 100
// delay from final reference to power-good, in ns
`define PG_DELAY_NS 93000
// threshold boost hold after a voltage transition, in ns
`define BOOST_HOLD_NS 50000
// least times round up to whole cycles
`define PG_DELAY_CYCLES ((`PG_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOOST_HOLD_CYCLES ((`BOOST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// overcurrent events in a row, the last of which latches off
`define OC_RETRY_LIMIT 5
// no-processor code of the five-bit table
`define NO_CPU_CODE 5'h1f

// register offsets
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04
// control fields and reset value
`define CTRL_MODE_BIT 0
`define CTRL_RESET 32'h0000_0000
// status fields
`define STAT_STATE_LSB 0
`define STAT_RETRY_LSB 4
`define STAT_UV_BIT 8
`define STAT_OV_CLAMP_BIT 9
`define STAT_OV_SEEN_BIT 10
`define STAT_BOOST_BIT 11
`define STAT_PG_BIT 12

`endif

/* File: core/fault_supervisor_pkg.sv */
/*
  types for the regulator fault supervisor: states, threshold selects and
  the comparator bundles.
  assumes the analog comparators deliver clean synchronous levels.
*/
package fault_supervisor_pkg;

  // supervisor states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_SOFT,
    ST_RETRY,
    ST_RUN,
    ST_LATCH
  } fsm_state_t;

  // overvoltage trip level choice for the analog side
  typedef enum logic [1:0] {
    OV_FLOOR_175,
    OV_REF_175,
    OV_REF_225
  } ov_level_t;

  // comparator results on the output and the total current
  typedef struct packed {
    logic ov_trip;          // sense above selected trip level
    logic ov_above_release; // sense above trip level minus 100mV
    logic uv_below_low;     // sense below reference minus 350mV
    logic uv_above_high;    // sense above reference minus 250mV
    logic avg_over;         // average current above selected trip
    logic monitor_over;     // current monitor pin above 2.0V
  } sense_cmp_t;

  // threshold selects driven back to the analog side
  typedef struct packed {
    ov_level_t ov_level;
    logic avg_boost;        // 140uA instead of 100uA
    logic limit_boost;      // 196uA instead of 140uA
  } level_sel_t;

endpackage

/* File: core/regulator_fault_supervisor.sv */
/*
  fault supervision for a multi-phase buck controller: power-good, latch-off,
  hiccup retry, overvoltage clamp, per-channel limit and threshold boost.
  assumes comparator inputs, enable and power-on status are synchronous to
  clk, and that an external sequencer runs soft-start while asked to.
*/
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "fault_supervisor_defines.svh"

module regulator_fault_supervisor #(
  parameter int CHANNELS = 2,
  parameter int PG_DELAY_CYCLES = `PG_DELAY_CYCLES,
  parameter int BOOST_HOLD_CYCLES = `BOOST_HOLD_CYCLES,
  parameter int RETRY_LIMIT = `OC_RETRY_LIMIT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // supervision inputs
  input wire logic por_ok,
  input wire logic enable,
  input wire logic dvid_active,
  input wire logic [4:0] voltage_id_code,
  input wire logic five_bit_table,
  // soft-start sequencer
  output logic soft_start_run,
  input wire logic soft_start_done,
  // comparators and threshold selects
  input wire fault_supervisor_pkg::sense_cmp_t sense,
  input wire logic [CHANNELS-1:0] channel_current_limit,
  output fault_supervisor_pkg::level_sel_t level_sel,
  // gate drives
  input wire logic [CHANNELS-1:0] pwm_high,
  output logic [CHANNELS-1:0] high_side_gate,
  output logic [CHANNELS-1:0] low_side_gate,
  // open-drain power-good
  output logic power_good_out_o,
  output logic power_good_out_oe
);

  localparam int PGW = $clog2(PG_DELAY_CYCLES + 1);
  localparam int BHW = $clog2(BOOST_HOLD_CYCLES + 1);
  localparam logic [PGW-1:0] PG_FULL = PGW'(PG_DELAY_CYCLES);
  localparam logic [BHW-1:0] BOOST_LOAD = BHW'(BOOST_HOLD_CYCLES);
  localparam logic [2:0] RETRY_MAX = 3'(RETRY_LIMIT);

  // decode of the no-processor code, used at start and while running
  function automatic logic is_no_cpu(input logic [4:0] code, input logic five);
    is_no_cpu = five && (code == `NO_CPU_CODE);
  endfunction

  fault_supervisor_pkg::fsm_state_t state;   // supervisor state
  fault_supervisor_pkg::fsm_state_t next_state;
  logic ctrl_mode;        // 0 first processor mode, 1 second
  logic [2:0] retry_count; // overcurrent events since last success
  logic ov_clamp;         // low-side clamp engaged
  logic ov_seen;          // one soft-start ov already forgiven
  logic uv_flag;          // output below undervoltage window
  logic [PGW-1:0] pg_count; // power-good delay counter
  logic [BHW-1:0] boost_count; // boost hold after transition
  logic pg_good;          // registered power-good
  logic pg_hold;          // second-mode hold across shutdown
  logic disabled;         // enable low or power not ready
  logic no_cpu;           // no-processor code applied
  logic oc_trip;          // any total overcurrent indication
  logic ov_end;           // clamp releasing this cycle
  logic ov_latch_evt;     // release that must latch off
  logic active;           // soft-start or regulating
  logic window;           // output inside the uv/ov window
  logic pg_ready;         // first-mode delay elapsed
  logic boost;            // thresholds raised

  assign disabled = !enable || !por_ok;
  assign no_cpu = is_no_cpu(voltage_id_code, five_bit_table);
  assign oc_trip = sense.avg_over || sense.monitor_over;
  assign active = (state == fault_supervisor_pkg::ST_SOFT) ||
                  (state == fault_supervisor_pkg::ST_RUN);
  assign window = !uv_flag && !ov_clamp;
  assign pg_ready = (pg_count == PG_FULL);
  // clamp lets go once the sense is 100mV under the trip level
  assign ov_end = ov_clamp && !sense.ov_trip && !sense.ov_above_release;
  // the first release inside soft-start is forgiven, later ones latch
  assign ov_latch_evt = ov_end &&
    !((state == fault_supervisor_pkg::ST_SOFT) && !ov_seen);
  assign soft_start_run = active;

  // control register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_mode <= 1'(`CTRL_RESET >> `CTRL_MODE_BIT);
    end else if (reg_write && reg_addr == `REG_CTRL_OFS) begin
      ctrl_mode <= reg_wdata[`CTRL_MODE_BIT];
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      reg_rdata <= 32'h0;
      case (reg_addr)
        `REG_CTRL_OFS: begin
          reg_rdata[`CTRL_MODE_BIT] <= ctrl_mode;
        end
        `REG_STATUS_OFS: begin
          reg_rdata[`STAT_STATE_LSB +: 3] <= state;
          reg_rdata[`STAT_RETRY_LSB +: 3] <= retry_count;
          reg_rdata[`STAT_UV_BIT] <= uv_flag;
          reg_rdata[`STAT_OV_CLAMP_BIT] <= ov_clamp;
          reg_rdata[`STAT_OV_SEEN_BIT] <= ov_seen;
          reg_rdata[`STAT_BOOST_BIT] <= boost;
          reg_rdata[`STAT_PG_BIT] <= pg_good;
        end
        default: begin
          reg_rdata <= 32'h0;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // next state; disable wins over every fault
  always_comb begin
    next_state = state;
    case (state)
      fault_supervisor_pkg::ST_OFF: begin
        if (!disabled && !no_cpu) begin
          next_state = fault_supervisor_pkg::ST_SOFT;
        end
      end
      fault_supervisor_pkg::ST_SOFT, fault_supervisor_pkg::ST_RUN: begin
        if (disabled) begin
          next_state = fault_supervisor_pkg::ST_OFF;
        end else if (ov_latch_evt) begin
          next_state = fault_supervisor_pkg::ST_LATCH;
        end else if (no_cpu) begin
          // first mode latches, second just shuts down and waits
          next_state = ctrl_mode ? fault_supervisor_pkg::ST_OFF
                                 : fault_supervisor_pkg::ST_LATCH;
        end else if (oc_trip) begin
          // fifth event in a row latches, earlier ones retry
          next_state = (retry_count + 3'h1 >= RETRY_MAX) ?
            fault_supervisor_pkg::ST_LATCH : fault_supervisor_pkg::ST_RETRY;
        end else if (state == fault_supervisor_pkg::ST_SOFT && soft_start_done) begin
          next_state = fault_supervisor_pkg::ST_RUN;
        end
      end
      fault_supervisor_pkg::ST_RETRY: begin
        // one idle cycle restarts the sequencer from scratch
        next_state = disabled ? fault_supervisor_pkg::ST_OFF
                              : fault_supervisor_pkg::ST_SOFT;
      end
      fault_supervisor_pkg::ST_LATCH: begin
        // only an enable toggle or power loss leaves latch-off
        if (disabled) begin
          next_state = fault_supervisor_pkg::ST_OFF;
        end
      end
      default: begin
        next_state = fault_supervisor_pkg::ST_OFF;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= fault_supervisor_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // overcurrent retry counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      retry_count <= 3'h0;
    end else if (disabled) begin
      retry_count <= 3'h0;
    end else if (active && oc_trip && !ov_latch_evt && !no_cpu) begin
      if (retry_count < RETRY_MAX) begin
        retry_count <= retry_count + 3'h1;
      end
    end else if (state == fault_supervisor_pkg::ST_SOFT && soft_start_done) begin
      retry_count <= 3'h0;
    end
  end

  // overvoltage clamp; a new trip wins over the release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_clamp <= 1'b0;
    end else if (sense.ov_trip) begin
      ov_clamp <= 1'b1;
    end else if (!sense.ov_above_release) begin
      ov_clamp <= 1'b0;
    end
  end

  // memory of the one forgiven soft-start trip
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_seen <= 1'b0;
    end else if (state == fault_supervisor_pkg::ST_OFF) begin
      ov_seen <= 1'b0;
    end else if (ov_end && state == fault_supervisor_pkg::ST_SOFT) begin
      ov_seen <= 1'b1;
    end
  end

  // undervoltage with hysteresis; only power-good reacts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_flag <= 1'b0;
    end else if (sense.uv_below_low) begin
      uv_flag <= 1'b1;
    end else if (sense.uv_above_high) begin
      uv_flag <= 1'b0;
    end
  end

  // first-mode delay from final reference to power-good
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_count <= '0;
    end else if (state != fault_supervisor_pkg::ST_RUN) begin
      pg_count <= '0;
    end else if (!pg_ready) begin
      pg_count <= pg_count + PGW'(1);
    end
  end

  // second-mode hold: survives shutdown, ends when the window is left
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_hold <= 1'b0;
    end else if (!window || !ctrl_mode) begin
      pg_hold <= 1'b0;
    end else if (pg_good) begin
      pg_hold <= 1'b1;
    end
  end

  // power-good; ov and uv pull it low, as does every non-run state unless the second-mode hold is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_good <= 1'b0;
    end else if (ctrl_mode) begin
      pg_good <= window && (state == fault_supervisor_pkg::ST_RUN || pg_hold);
    end else begin
      pg_good <= window && pg_ready &&
                 (state == fault_supervisor_pkg::ST_RUN);
    end
  end

  // open-drain: only ever pulls low
  assign power_good_out_o = 1'b0;
  assign power_good_out_oe = !pg_good;

  // boost hold timer restarts at every transition cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boost_count <= '0;
    end else if (dvid_active) begin
      boost_count <= BOOST_LOAD;
    end else if (boost_count != '0) begin
      boost_count <= boost_count - BHW'(1);
    end
  end

  // selects are combinational so a boost starts with the transition
  assign boost = dvid_active || (boost_count != '0);
  always_comb begin
    level_sel.avg_boost = boost;
    level_sel.limit_boost = boost;
    if (ctrl_mode) begin
      level_sel.ov_level = fault_supervisor_pkg::OV_REF_225;
    end else if (state == fault_supervisor_pkg::ST_RUN) begin
      level_sel.ov_level = fault_supervisor_pkg::OV_REF_175;
    end else begin
      level_sel.ov_level = fault_supervisor_pkg::OV_FLOOR_175;
    end
  end

  // per-channel gate override; clamp and limit only ever raise the low side
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_gate
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          high_side_gate[ch] <= 1'b0;
          low_side_gate[ch] <= 1'b0;
        end else if (ov_clamp) begin
          high_side_gate[ch] <= 1'b0;
          low_side_gate[ch] <= 1'b1;
        end else if (!active || oc_trip) begin
          // shutdown, retry gap and overcurrent: both devices off
          high_side_gate[ch] <= 1'b0;
          low_side_gate[ch] <= 1'b0;
        end else if (channel_current_limit[ch]) begin
          // the rest of the regulator keeps switching
          high_side_gate[ch] <= 1'b0;
          low_side_gate[ch] <= 1'b1;
        end else begin
          high_side_gate[ch] <= pwm_high[ch];
          low_side_gate[ch] <= !pwm_high[ch];
        end
      end
    end
  endgenerate

  // checks next to the logic
  gate_exclusive_a: assert property (@(posedge clk) disable iff (!rst_n)
    (high_side_gate & low_side_gate) == '0)
    else $error("both gates of a channel high");

  pg_before_ss_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl_mode && state != fault_supervisor_pkg::ST_RUN) |=> !pg_good)
    else $error("power-good high before soft-start end");

  pg_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(pg_good) && !ctrl_mode) |-> $past(pg_count) == PG_FULL)
    else $error("power-good rose before delay elapsed");

  ov_clamp_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    ov_clamp |=> (&low_side_gate) && (high_side_gate == '0) && !pg_good)
    else $error("overvoltage clamp not applied");

  limit_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    (channel_current_limit[0] && active && !oc_trip && !ov_clamp) |=>
      !high_side_gate[0] && low_side_gate[0])
    else $error("channel limit did not override gates");

  retry_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == fault_supervisor_pkg::ST_RETRY && !disabled) |=>
      state == fault_supervisor_pkg::ST_SOFT && soft_start_run)
    else $error("retry did not restart soft-start");

  latch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == fault_supervisor_pkg::ST_LATCH && !disabled) |=>
      state == fault_supervisor_pkg::ST_LATCH)
    else $error("latch-off left without enable toggle");

  retry_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    (retry_count == RETRY_MAX - 3'h1 && active && oc_trip && !disabled &&
     !ov_latch_evt && !no_cpu) |=> state == fault_supervisor_pkg::ST_LATCH)
    else $error("fifth overcurrent did not latch");

  boost_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dvid_active) |-> (level_sel.avg_boost && level_sel.limit_boost)[*8])
    else $error("boost dropped right after transition");

  nocpu_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == fault_supervisor_pkg::ST_OFF && no_cpu) |=>
      state == fault_supervisor_pkg::ST_OFF)
    else $error("soft-start began with no-cpu code");

  mode2_pg_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_mode && state == fault_supervisor_pkg::ST_RUN && window) |=> pg_good)
    else $error("second mode power-good not high in window");

  uv_pg_a: assert property (@(posedge clk) disable iff (!rst_n)
    uv_flag |=> !pg_good)
    else $error("power-good high during undervoltage");

endmodule // regulator_fault_supervisor

/* File: verification/pg_monitor.sv */
/*
  system monitor model that reads the open-drain power-good line.
  assumes a pull-up on the line, so a released pin reads high.
*/
`timescale 1ns/1ps

module pg_monitor (
  // pin drive from the supervisor
  input wire logic pg_o,
  input wire logic pg_oe,
  // level seen by the monitor
  output logic pg_level
);
  // pull-up wins whenever the pin is released, never the last driven value
  assign pg_level = pg_oe ? pg_o : 1'b1;
endmodule // pg_monitor

/* File: verification/tb_top.sv */
/*
  bench for the fault supervisor: power-good, faults, limits, registers.
  assumes ideal comparator levels driven by the bench and short delays.
*/
`timescale 1ns/1ps

module tb_top;
  localparam int PGD = 20; // short power-good delay
  localparam int BH = 10; // short boost hold
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic por_ok = 1'b1;
  logic enable = 1'b0;
  logic dvid_active = 1'b0;
  logic [4:0] voltage_id_code = 5'h00;
  logic five_bit_table = 1'b0;
  logic soft_start_run;
  logic soft_start_done = 1'b0;
  fault_supervisor_pkg::sense_cmp_t sense = 6'h04; // inside the window
  logic [1:0] channel_current_limit = 2'h0;
  fault_supervisor_pkg::level_sel_t level_sel;
  logic [1:0] pwm_high = 2'h3;
  logic [1:0] high_side_gate;
  logic [1:0] low_side_gate;
  logic pg_o;
  logic pg_oe;
  logic pg_level;
  logic [31:0] d;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  regulator_fault_supervisor #(.PG_DELAY_CYCLES(PGD), .BOOST_HOLD_CYCLES(BH))
  i_regulator_fault_supervisor (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .por_ok(por_ok), .enable(enable), .dvid_active(dvid_active),
    .voltage_id_code(voltage_id_code), .five_bit_table(five_bit_table),
    .soft_start_run(soft_start_run), .soft_start_done(soft_start_done),
    .sense(sense), .channel_current_limit(channel_current_limit),
    .level_sel(level_sel), .pwm_high(pwm_high), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .power_good_out_o(pg_o), .power_good_out_oe(pg_oe)
  );

  pg_monitor i_pg_monitor (.pg_o(pg_o), .pg_oe(pg_oe), .pg_level(pg_level));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // sampled at an edge, so it sees the value settled in the cycle before
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // bounded wait for the monitor to see a level
  task automatic wait_pg(input logic v, input int lim);
    int i;
    i = 0;
    while (pg_level !== v && i < lim) begin
      @(posedge clk);
      i++;
    end
    chk(pg_level, v);
  endtask

  // enable toggle, soft-start left waiting for done
  task automatic go();
    enable <= 1'b0;
    soft_start_done <= 1'b0;
    cyc(3);
    enable <= 1'b1;
    cyc(4);
  endtask

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(2);
    chk(pg_level, 1'b0);
    rd(8'h00);
    chk(d, 32'h0);
    rd(8'h08);
    chk(d, 32'h0);
    endt("reset");
    // first mode start-up
    go();
    chk(soft_start_run, 1'b1);
    chk(level_sel.ov_level, fault_supervisor_pkg::OV_FLOOR_175);
    chk(pg_level, 1'b0);
    soft_start_done <= 1'b1;
    cyc(PGD - 3);
    chk(pg_level, 1'b0);
    wait_pg(1'b1, 12);
    chk(level_sel.ov_level, fault_supervisor_pkg::OV_REF_175);
    endt("startup");
    // undervoltage with hysteresis
    sense.uv_below_low <= 1'b1;
    sense.uv_above_high <= 1'b0;
    wait_pg(1'b0, 4);
    sense.uv_below_low <= 1'b0;
    cyc(4);
    chk(pg_level, 1'b0);
    chk(soft_start_run, 1'b1);
    sense.uv_above_high <= 1'b1;
    wait_pg(1'b1, PGD + 8);
    endt("undervoltage");
    // channel limit on channel 0 only
    channel_current_limit <= 2'h1;
    cyc(3);
    chk(high_side_gate, 2'h2);
    chk(low_side_gate[0], 1'b1);
    cyc(3);
    chk(high_side_gate[0], 1'b0);
    channel_current_limit <= 2'h0;
    cyc(3);
    chk(high_side_gate, 2'h3);
    endt("channel limit");
    // threshold boost around a transition
    dvid_active <= 1'b1;
    cyc(2);
    chk(level_sel.avg_boost, 1'b1);
    chk(level_sel.limit_boost, 1'b1);
    dvid_active <= 1'b0;
    cyc(BH - 3);
    chk({level_sel.avg_boost, level_sel.limit_boost}, 2'h3);
    cyc(6);
    chk({level_sel.avg_boost, level_sel.limit_boost}, 2'h0);
    endt("boost");
    // one average-current trip, then retry
    sense.avg_over <= 1'b1;
    soft_start_done <= 1'b0;
    cyc(1);
    sense.avg_over <= 1'b0;
    wait_pg(1'b0, 3);
    rd(8'h04);
    chk(d[6:0], 7'h11);
    // monitor pin trip held until the fifth event latches
    sense.monitor_over <= 1'b1;
    cyc(20);
    sense.monitor_over <= 1'b0;
    rd(8'h04);
    chk(d[2:0], 3'h4);
    chk(high_side_gate, 2'h0);
    go();
    rd(8'h04);
    chk(d[6:0], 7'h01);
    endt("overcurrent");
    // overvoltage while running
    soft_start_done <= 1'b1;
    wait_pg(1'b1, PGD + 8);
    sense.ov_trip <= 1'b1;
    sense.ov_above_release <= 1'b1;
    cyc(4);
    chk(low_side_gate, 2'h3);
    chk(high_side_gate, 2'h0);
    chk(pg_level, 1'b0);
    sense.ov_trip <= 1'b0;
    cyc(4);
    chk(low_side_gate, 2'h3);
    sense.ov_above_release <= 1'b0;
    cyc(4);
    rd(8'h04);
    chk(d[2:0], 3'h4);
    chk(pg_level, 1'b0);
    endt("overvoltage");
    // soft-start overvoltage: first forgiven, second latches
    go();
    sense.ov_trip <= 1'b1;
    cyc(4);
    chk(low_side_gate, 2'h3);
    sense.ov_trip <= 1'b0;
    cyc(4);
    rd(8'h04);
    chk(d[2:0], 3'h1);
    sense.ov_trip <= 1'b1;
    cyc(3);
    sense.ov_trip <= 1'b0;
    cyc(4);
    rd(8'h04);
    chk(d[2:0], 3'h4);
    endt("soft overvoltage");
    // second mode: no delay, power-good held past shutdown
    wr(8'h00, 32'h1);
    go();
    chk(level_sel.ov_level, fault_supervisor_pkg::OV_REF_225);
    soft_start_done <= 1'b1;
    wait_pg(1'b1, 4);
    chk(level_sel.ov_level, fault_supervisor_pkg::OV_REF_225);
    enable <= 1'b0;
    cyc(4);
    chk(pg_level, 1'b1);
    sense.uv_below_low <= 1'b1;
    sense.uv_above_high <= 1'b0;
    wait_pg(1'b0, 4);
    sense.uv_below_low <= 1'b0;
    sense.uv_above_high <= 1'b1;
    endt("second mode");
    // no-processor code blocks the start
    five_bit_table <= 1'b1;
    voltage_id_code <= 5'h1f;
    enable <= 1'b1;
    cyc(4);
    chk(soft_start_run, 1'b0);
    voltage_id_code <= 5'h00;
    cyc(4);
    chk(soft_start_run, 1'b1);
    endt("no processor");
    // no-cpu while running: second mode shuts down, first mode latches
    voltage_id_code <= 5'h1f;
    cyc(3);
    chk(soft_start_run, 1'b0);
    voltage_id_code <= 5'h00;
    wr(8'h00, 32'h0);
    voltage_id_code <= 5'h1f;
    cyc(2);
    chk(soft_start_run, 1'b0);
    voltage_id_code <= 5'h00;
    cyc(4);
    chk(soft_start_run, 1'b0);
    chk(pg_level, 1'b0);
    // power loss clears latch-off and drops power-good
    por_ok <= 1'b0;
    cyc(2);
    por_ok <= 1'b1;
    wait_pg(1'b1, PGD + 8);
    por_ok <= 1'b0;
    wait_pg(1'b0, 4);
    chk(soft_start_run, 1'b0);
    por_ok <= 1'b1;
    endt("latch and power");
    report_and_stop();
  end
endmodule // tb_top
